// >>> hdl/adc_seq_pkg.sv
/*
 * constants, register map and state type of the conversion sequencer.
 * assumes a 32-bit apb slave with byte addresses on an 8-bit offset.
 */
package adc_seq_pkg;
   // ************************************************
   // sizes
   // ************************************************
   localparam int NUM_SLOTS = 8;
   localparam int SLOT_W    = 3;
   localparam int NUM_PPB   = 4;
   localparam int NUM_LINES = 4;
   localparam int ADDR_W    = 8;
   localparam int CH_W      = 5;
   localparam int ACQ_W     = 9;
   localparam int CFG_W     = 18;
   localparam int DLY_W     = 16;

   // ************************************************
   // register offsets
   // ************************************************
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] FORCE_OFS  = 8'h04;
   localparam logic [7:0] PEND_OFS   = 8'h08;
   localparam logic [7:0] IRQSEL_OFS = 8'h0c;
   localparam logic [7:0] FLAG_OFS   = 8'h10;
   localparam logic [7:0] MASK_OFS   = 8'h14;
   localparam logic [1:0] SLOT_REGION = 2'b01;
   localparam logic [1:0] RES_REGION  = 2'b10;
   localparam logic [1:0] PPB_REGION  = 2'b11;

   // ************************************************
   // control fields
   // ************************************************
   localparam int CTRL_EN_BIT    = 0;
   localparam int CTRL_EARLY_BIT = 1;
   localparam int CTRL_RES16_BIT = 2;
   localparam int CTRL_HP_LSB    = 4;
   localparam int CTRL_BURST_BIT = 8;
   localparam int CTRL_BSIZE_LSB = 9;
   localparam int CTRL_BTRIG_LSB = 12;
   localparam int CFG_CH_LSB     = 4;
   localparam int CFG_ACQ_LSB    = 9;
   localparam int PPB_TRIP_BIT   = 3;
   localparam int PPB_IRQ_BIT    = 4;

   // ************************************************
   // trigger source codes
   // ************************************************
   localparam logic [3:0] TRIG_SW_ONLY = 4'h0;
   localparam int         TRIG_TMR_LSB = 1;
   localparam int         TRIG_PWM_LSB = 4;
   localparam int         TRIG_EXT     = 12;
   localparam int         TRIG_LINE1   = 13;
   localparam int         TRIG_LINE2   = 14;

   // ************************************************
   // reset values
   // ************************************************
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [7:0]  MASK_RST = 8'h00;
   localparam logic [2:0]  RR_PTR_RST = 3'h7; // parked on the last slot so slot_zero goes first

   typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV, ST_WRITE} conv_state_t;
endpackage : adc_seq_pkg

// >>> hdl/adc_conversion_sequencer.sv
/*
 * conversion slots, trigger arbitration, interrupt lines and four
 * post-processing units of a successive-approximation converter.
 * assumes the sar core shares pclk and answers conv_start with one conv_done.
 */
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
module adc_conversion_sequencer (
   // clock and reset
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   // apb slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [adc_seq_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   // trigger sources
   input  wire logic [2:0]                    timer_trig,
   input  wire logic [7:0]                    pwm_trig,
   input  wire logic                          ext_trig_pin,
   // sar core
   output logic                               sample_hold,
   output logic                               conv_start,
   output logic      [adc_seq_pkg::CH_W-1:0]  conv_channel,
   output logic                               conv_diff,
   input  wire logic                          conv_done,
   input  wire logic [15:0]                   conv_data,
   // events
   output logic      [3:0]                    adc_irq_lines,
   output logic                               irq,
   output logic      [3:0]                    pwm_trip
);
   import adc_seq_pkg::*;
   // ************************************************
   // registers and state
   // ************************************************
   conv_state_t              state;
   logic [31:0]              ctrl;
   logic [15:0]              irq_sel;
   logic [7:0]               flag;
   logic [7:0]               mask;
   logic [NUM_SLOTS-1:0]     pending;
   logic [CFG_W-1:0]         slot_cfg [NUM_SLOTS];
   logic [15:0]              result   [NUM_SLOTS];
   logic [DLY_W-1:0]         dly      [NUM_SLOTS];
   logic [SLOT_W-1:0]        cur_slot;
   logic [SLOT_W-1:0]        rr_ptr;
   logic [ACQ_W-1:0]         acq_cnt;
   logic [DLY_W-1:0]         cur_dly;
   logic [15:0]              conv_word;
   logic                     ext_meta;
   logic                     ext_sync;
   logic                     ext_prev;
   logic [31:0]              ppb_cfg  [NUM_PPB];
   logic [31:0]              ppb_ref  [NUM_PPB];
   logic [31:0]              ppb_lim  [NUM_PPB];
   logic [15:0]              ppb_out  [NUM_PPB];
   logic [DLY_W-1:0]         ppb_dly  [NUM_PPB];
   logic [NUM_PPB-1:0]       ppb_evt;
   // ************************************************
   // apb decode
   // ************************************************
   wire                      wr_en     = psel && penable && pwrite;
   wire                      setup     = psel && !penable;
   wire [1:0]                region    = paddr[7:6];
   wire [SLOT_W-1:0]         slot_idx  = paddr[4:2];
   wire [1:0]                ppb_idx   = paddr[5:4];
   wire [1:0]                ppb_reg   = paddr[3:2];
   wire                      in_slot   = region == SLOT_REGION && !paddr[5];
   wire                      in_res    = region == RES_REGION && !paddr[5];
   wire                      in_ppb    = region == PPB_REGION;
   wire                      in_low    = region == 2'b00 && paddr <= MASK_OFS && paddr[1:0] == 2'b00;
   wire                      mapped    = (in_low || in_slot || in_res || in_ppb) && paddr[1:0] == 2'b00;
   wire [31:0]               ppb_word  = ppb_reg == 2'd0 ? ppb_cfg[ppb_idx] :
                                         ppb_reg == 2'd1 ? ppb_ref[ppb_idx] :
                                         ppb_reg == 2'd2 ? ppb_lim[ppb_idx] :
                                         {ppb_dly[ppb_idx], ppb_out[ppb_idx]};
   wire [31:0]               rd_mux    = paddr == CTRL_OFS   ? ctrl :
                                         paddr == PEND_OFS   ? {24'h0, pending} :
                                         paddr == IRQSEL_OFS ? {16'h0, irq_sel} :
                                         paddr == FLAG_OFS   ? {24'h0, flag} :
                                         paddr == MASK_OFS   ? {24'h0, mask} :
                                         in_slot ? {14'h0, slot_cfg[slot_idx]} :
                                         in_res  ? {16'h0, result[slot_idx]} :
                                         in_ppb  ? ppb_word : 32'h0;
   // zero-wait slave: read data is latched in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (setup) begin
         prdata <= mapped ? rd_mux : 32'h0;
      end
   end
   // ************************************************
   // control fields
   // ************************************************
   wire                      enable    = ctrl[CTRL_EN_BIT];
   wire                      eoc_early = ctrl[CTRL_EARLY_BIT];
   wire                      res16     = ctrl[CTRL_RES16_BIT];
   wire [3:0]                hp_count  = ctrl[CTRL_HP_LSB +: 4];
   wire                      burst_en  = ctrl[CTRL_BURST_BIT];
   wire [2:0]                burst_sz  = ctrl[CTRL_BSIZE_LSB +: 3];
   wire [3:0]                burst_src = ctrl[CTRL_BTRIG_LSB +: 4];
   // ************************************************
   // trigger events
   // ************************************************
   logic [NUM_LINES-1:0]     line_set;
   logic                     eoc;
   wire                      ext_rise  = ext_sync && !ext_prev;
   wire [15:0]               trig_evt  = {1'b0, line_set[1], line_set[0], ext_rise,
                                          pwm_trig, timer_trig, 1'b0};
   wire                      force_wr  = wr_en && paddr == FORCE_OFS;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         ext_prev <= 1'b0;
      end else begin
         ext_meta <= ext_trig_pin;
         ext_sync <= ext_meta;
         ext_prev <= ext_sync;
      end
   end
   // ************************************************
   // slot triggering and burst
   // ************************************************
   logic [NUM_SLOTS-1:0]     trig_set;
   logic [NUM_SLOTS-1:0]     burst_set;
   logic [NUM_SLOTS-1:0]     hp_mask;
   wire                      burst_hit = burst_en && trig_evt[burst_src];
   always_comb begin
      logic [SLOT_W-1:0] b_idx;
      b_idx     = '0;
      burst_set = '0;
      for (int k = 1; k <= NUM_SLOTS; k++) begin
         b_idx = rr_ptr + k[SLOT_W-1:0];
         if (burst_hit && k <= int'(burst_sz) + 1 && !hp_mask[b_idx]) begin
            burst_set[b_idx] = 1'b1;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
         wire [3:0] src = slot_cfg[gi][3:0];
         assign hp_mask[gi]  = gi < int'(hp_count);
         // in burst mode only high priority slots keep their own trigger
         assign trig_set[gi] = src != TRIG_SW_ONLY && trig_evt[src]
                               && (!burst_en || hp_mask[gi]);

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               slot_cfg[gi] <= '0;
            end else if (wr_en && in_slot && slot_idx == gi) begin
               slot_cfg[gi] <= pwdata[CFG_W-1:0];
            end
         end
         // counts while the slot is pending, holding at all ones; clears only in a cycle where the slot is not pending
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dly[gi] <= '0;
            end else if (!pending[gi]) begin
               dly[gi] <= '0;
            end else if (dly[gi] != '1) begin
               dly[gi] <= dly[gi] + 16'h1;
            end
         end
      end
   endgenerate
   // ************************************************
   // arbitration
   // ************************************************
   logic [SLOT_W-1:0]        pick;
   logic                     hp_hit;
   wire [SLOT_W-1:0]         next_rr = rr_ptr + 3'h1;
   wire                      go      = state == ST_IDLE && enable && |pending;
   always_comb begin
      logic [SLOT_W-1:0] idx;
      idx    = '0;
      pick   = '0;
      hp_hit = 1'b0;
      for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
         if (pending[i] && hp_mask[i]) begin
            pick   = i[SLOT_W-1:0];
            hp_hit = 1'b1;
         end
      end
      if (!hp_hit) begin
         // nearest pending slot after the pointer, wrapping round
         for (int k = NUM_SLOTS; k >= 1; k--) begin
            idx = rr_ptr + k[SLOT_W-1:0];
            if (pending[idx]) begin
               pick = idx;
            end
         end
      end
   end
   wire [NUM_SLOTS-1:0]      start_clr = go ? NUM_SLOTS'(1) << pick : '0;
   // ************************************************
   // conversion sequence
   // ************************************************
   assign sample_hold = state == ST_ACQ;
   assign conv_diff   = res16;
   assign eoc = eoc_early ? (state == ST_ACQ && acq_cnt == '0)
                          : (state == ST_CONV && conv_done);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending <= '0;
      end else begin
         // a trigger arriving as the slot starts is kept for a second pass
         pending <= (pending & ~start_clr) | trig_set | burst_set
                    | (force_wr ? pwdata[NUM_SLOTS-1:0] : '0);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state        <= ST_IDLE;
         cur_slot     <= '0;
         rr_ptr       <= RR_PTR_RST;
         acq_cnt      <= '0;
         cur_dly      <= '0;
         conv_start   <= 1'b0;
         conv_channel <= '0;
         conv_word    <= '0;
      end else begin
         conv_start <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (go) begin
                  state        <= ST_ACQ;
                  cur_slot     <= pick;
                  conv_channel <= slot_cfg[pick][CFG_CH_LSB +: CH_W];
                  acq_cnt      <= slot_cfg[pick][CFG_ACQ_LSB +: ACQ_W];
                  cur_dly      <= dly[pick];
                  if (!hp_hit) begin
                     rr_ptr <= pick;
                  end
               end
            end
            ST_ACQ: begin
               if (acq_cnt == '0) begin
                  state      <= ST_CONV;
                  conv_start <= 1'b1;
               end else begin
                  acq_cnt <= acq_cnt - 9'h1;
               end
            end
            ST_CONV: begin
               if (conv_done) begin
                  state     <= ST_WRITE;
                  conv_word <= res16 ? conv_data : {4'h0, conv_data[11:0]};
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   generate
      for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_res
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               result[gi] <= '0;
            end else if (state == ST_WRITE && cur_slot == gi) begin
               result[gi] <= conv_word;
            end
         end
      end
   endgenerate
   // ************************************************
   // post-processing units
   // ************************************************
   generate
      for (gi = 0; gi < NUM_PPB; gi++) begin : g_ppb
         wire               sel_wr = wr_en && in_ppb && ppb_idx == gi;
         wire               hit    = state == ST_WRITE && cur_slot == ppb_cfg[gi][SLOT_W-1:0];
         wire signed [15:0] corr   = conv_word - ppb_ref[gi][15:0];
         wire signed [15:0] err    = corr - ppb_ref[gi][31:16];
         wire signed [15:0] lo     = ppb_lim[gi][15:0];
         wire signed [15:0] hi     = ppb_lim[gi][31:16];
         logic              prev_sign;
         logic              have_prev;
         wire               trip   = hit && (err > hi || err < lo
                                     || (have_prev && prev_sign != err[15]));
         assign ppb_evt[gi] = trip && ppb_cfg[gi][PPB_IRQ_BIT];

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ppb_cfg[gi]  <= '0;
               ppb_ref[gi]  <= '0;
               ppb_lim[gi]  <= '0;
               ppb_out[gi]  <= '0;
               ppb_dly[gi]  <= '0;
               prev_sign    <= 1'b0;
               have_prev    <= 1'b0;
               pwm_trip[gi] <= 1'b0;
            end else begin
               if (sel_wr && ppb_reg == 2'd0) ppb_cfg[gi] <= {27'h0, pwdata[4:0]};
               if (sel_wr && ppb_reg == 2'd1) ppb_ref[gi] <= pwdata;
               if (sel_wr && ppb_reg == 2'd2) ppb_lim[gi] <= pwdata;
               pwm_trip[gi] <= trip && ppb_cfg[gi][PPB_TRIP_BIT];
               if (hit) begin
                  ppb_out[gi] <= err;
                  ppb_dly[gi] <= cur_dly;
                  prev_sign   <= err[15];
                  have_prev   <= 1'b1;
               end
            end
         end
      end
   endgenerate
   // ************************************************
   // interrupts
   // ************************************************
   generate
      for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
         assign line_set[gi] = eoc && irq_sel[4*gi+3]
                               && cur_slot == irq_sel[4*gi +: SLOT_W];
      end
   endgenerate

   wire [7:0] flag_set = {ppb_evt, line_set};
   wire [7:0] flag_clr = wr_en && paddr == FLAG_OFS ? pwdata[7:0] : 8'h0;
   assign adc_irq_lines = flag[3:0] & mask[3:0];
   assign irq           = |(flag & mask);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl    <= CTRL_RST;
         irq_sel <= '0;
         mask    <= MASK_RST;
         flag    <= '0;
      end else begin
         if (wr_en && paddr == CTRL_OFS)   ctrl    <= {16'h0, pwdata[15:0]};
         if (wr_en && paddr == IRQSEL_OFS) irq_sel <= pwdata[15:0];
         if (wr_en && paddr == MASK_OFS)   mask    <= pwdata[7:0];
         flag <= (flag & ~flag_clr) | flag_set; // set wins over clear
      end
   end
   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   one_conv_a: assert property (conv_start |=> !conv_start [*3])
      else $error("conversions overlap");
   hp_first_a: assert property (go && hp_hit |=> {1'b0, cur_slot} < hp_count)
      else $error("non high priority slot won");
   hp_low_a: assert property (go && pending[0] && hp_count != 4'h0 |=> cur_slot == 3'h0)
      else $error("lowest high priority slot not first");
   rr_next_a: assert property (go && !hp_hit && pending[next_rr] |=> cur_slot == $past(next_rr))
      else $error("round robin skipped next slot");
   rr_hold_a: assert property (go && hp_hit |=> rr_ptr == $past(rr_ptr))
      else $error("pointer moved on preemption");
   eoc_early_a: assert property (eoc && eoc_early |=> conv_start)
      else $error("early eoc not at conversion start");
   eoc_late_a: assert property (eoc && !eoc_early |=> state == ST_WRITE
      ##1 result[$past(cur_slot, 2)] == $past(conv_word))
      else $error("late eoc not one cycle before write");
   line_flag_a: assert property (line_set[0] |=> flag[0] && adc_irq_lines[0] == mask[0])
      else $error("line event lost");
   trig_take_a: assert property (trig_set[0] |=> pending[0])
      else $error("slot trigger lost");
   res12_a: assert property (state == ST_WRITE && !res16 |-> conv_word[15:12] == 4'h0)
      else $error("12-bit result has upper bits");
   dly_cap_a: assert property (go |=> cur_dly == $past(dly[pick]))
      else $error("delay not captured at start");
endmodule : adc_conversion_sequencer

// >>> dv/sar_core_model.sv
/* behavioural sar core: one conv_done per conv_start.
   assumes pclk is shared and one conversion runs at a time. */
`timescale 1ns/1ps
module sar_core_model #(
   parameter int LATENCY = 5
) (
   // clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // sequencer side
   input  wire logic                         conv_start,
   input  wire logic [adc_seq_pkg::CH_W-1:0] conv_channel,
   output logic                              conv_done,
   output logic      [15:0]                  conv_data
);
   import adc_seq_pkg::*;
   int            left;
   logic [CH_W-1:0] ch;
   // data toggles outside the done cycle so a late sample is caught
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left <= 0;
         ch <= '0;
         conv_done <= 1'b0;
         conv_data <= 16'h0000;
      end else begin
         conv_done <= 1'b0;
         conv_data <= ~conv_data;
         if (conv_start) begin
            left <= LATENCY;
            ch <= conv_channel;
         end else if (left == 1) begin
            conv_done <= 1'b1;
            conv_data <= {3'b101, ch, 8'h5c};
            left <= 0;
         end else if (left > 1) begin
            left <= left - 1;
         end
      end
   end
endmodule : sar_core_model

// >>> dv/adc_conversion_sequencer_test.sv
/* self-checking bench: apb master, random slot windows, arbitration corners.
   assumes sar_core_model answers each conversion after five cycles. */
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
   import adc_seq_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [2:0]        timer_trig;
   logic [7:0]        pwm_trig;
   logic              ext_trig_pin, sample_hold, conv_start, conv_diff, conv_done, irq;
   logic [CH_W-1:0]   conv_channel;
   logic [15:0]       conv_data;
   logic [3:0]        adc_irq_lines, pwm_trip;
   logic [CH_W-1:0]   ch [NUM_SLOTS];
   logic [CH_W-1:0]   order [$];
   int                miscompares, samples_checked, n_done, cycles, seed, k, n_hold, n_trip, t0, t1;

   adc_conversion_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_trig(timer_trig), .pwm_trig(pwm_trig), .ext_trig_pin(ext_trig_pin), .sample_hold(sample_hold),
      .conv_start(conv_start), .conv_channel(conv_channel), .conv_diff(conv_diff), .conv_done(conv_done),
      .conv_data(conv_data), .adc_irq_lines(adc_irq_lines), .irq(irq), .pwm_trip(pwm_trip));
   sar_core_model i_sar (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
      .conv_channel(conv_channel), .conv_done(conv_done), .conv_data(conv_data));

   always #4 pclk = ~pclk;

   // ************************************************
   // monitor and hang guard
   // ************************************************
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (conv_start === 1'b1) order.push_back(conv_channel);
      if (conv_done === 1'b1) n_done <= n_done + 1;
      if (sample_hold === 1'b1) n_hold <= n_hold + 1;
      if (pwm_trip === 4'h1) n_trip <= n_trip + 1;
      if (cycles == 30000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // result is written one cycle after done, so settle afterwards
   task wait_done(input int n);
      int goal;
      goal = n_done + n;
      for (int i = 0; i < 400 && n_done < goal; i++) @(posedge pclk);
      check(32'(n_done >= goal), 32'h1);
      repeat (3) @(posedge pclk);
   endtask : wait_done

   task check_order(input int exp[$]);
      foreach (exp[i]) check({27'h0, order[i]}, {27'h0, ch[exp[i]]});
   endtask : check_order

   function automatic logic [31:0] exp_result(input logic [CH_W-1:0] c);
      logic [15:0] d;
      d = {3'b101, c, 8'h5c};
      return {20'h00000, d[11:0]};
   endfunction : exp_result

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata, timer_trig, pwm_trig, ext_trig_pin} = '0;
      {miscompares, samples_checked, n_done, cycles, n_hold, n_trip} = '0;
      seed = 32'h34b3de05;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, CTRL_OFS, 0);
      check(rd, CTRL_RST);
      apb(0, MASK_OFS, 0);
      check(rd, {24'h0, MASK_RST});
      apb(0, 8'h18, 0);
      check({31'h0, err}, 32'h1);
      apb(1, CTRL_OFS, 32'h5);
      #1 check({31'h0, conv_diff}, 32'h1);
      apb(1, CTRL_OFS, 32'h1);
      for (k = 0; k < NUM_SLOTS; k++) begin
         ch[k] = 5'(k * 3 + 1);
         apb(1, 8'h40 + 8'(4 * k), {20'h0, 3'($random(seed)), ch[k], 4'h0});
      end
      order.delete();
      apb(1, FORCE_OFS, 32'h0e);
      wait_done(3);
      check_order({1, 2, 3});
      for (k = 1; k < 4; k++) begin
         apb(0, 8'h80 + 8'(4 * k), 0);
         check(rd, exp_result(ch[k]));
      end
      $display("round robin test done");
      apb(1, CTRL_OFS, 32'h21);
      order.delete();
      apb(1, FORCE_OFS, 32'hff);
      wait_done(8);
      check_order({0, 1, 4, 5, 6, 7, 2, 3});
      $display("priority test done");
      apb(1, IRQSEL_OFS, 32'h0d00);
      apb(1, MASK_OFS, 32'h04);
      for (k = 0; k < 2; k++) begin
         apb(1, CTRL_OFS, {30'h0, k[0], 1'b1});
         apb(1, FORCE_OFS, 32'h20);
         for (int i = 0; i < 100 && conv_start !== 1'b1; i++) @(posedge pclk);
         @(posedge pclk);
         #1 check({28'h0, adc_irq_lines}, k ? 32'h4 : 32'h0);
         wait_done(1);
         check({27'h0, irq, adc_irq_lines}, 32'h14);
         apb(1, FLAG_OFS, 32'h04);
         apb(0, FLAG_OFS, 0);
         check({rd[31:1], irq}, 32'h0);
      end
      apb(1, MASK_OFS, 32'h0);
      apb(1, FORCE_OFS, 32'h20);
      wait_done(1);
      apb(0, FLAG_OFS, 0);
      check({rd[31:1], irq}, 32'h4);
      apb(1, FLAG_OFS, 32'h04);
      $display("interrupt test done");
      for (k = 1; k <= 12; k++) begin
         ch[0] = 5'($random(seed));
         apb(1, 8'h40, {23'h0, ch[0], 4'(k)});
         order.delete();
         timer_trig <= (k <= 3) ? 3'b001 << (k - 1) : 3'h0;
         pwm_trig <= (k >= 4 && k <= 11) ? 8'h01 << (k - 4) : 8'h00;
         ext_trig_pin <= (k == 12);
         @(posedge pclk);
         timer_trig <= 3'h0;
         pwm_trig <= 8'h00;
         wait_done(1);
         ext_trig_pin <= 1'b0;
         check_order({0});
      end
      $display("trigger test done");
      k = $random(seed) & 7;
      apb(1, 8'h40, {20'h0, k[2:0], ch[0], 4'h0});
      apb(1, 8'hc0, 32'h18);
      apb(1, 8'hc4, 32'h0005_0023);
      apb(1, 8'hc8, 32'h0010_0000);
      t0 = n_hold;
      t1 = n_trip;
      apb(1, FORCE_OFS, 32'h01);
      wait_done(1);
      check(n_hold - t0, k + 1);
      check(n_trip - t1, 1);
      apb(0, 8'hcc, 0);
      check(rd, {16'h0, 16'(exp_result(ch[0]) - 32'h28)});
      apb(0, FLAG_OFS, 0);
      check(rd, 32'h10);
      apb(1, FLAG_OFS, 32'h10);
      $display("post processing test done");
      apb(1, CTRL_OFS, 32'h5);
      apb(1, 8'h4c, {23'h0, ch[3], 4'h2});
      apb(1, 8'h50, {23'h0, ch[4], 4'h2});
      order.delete();
      timer_trig <= 3'h2;
      @(posedge pclk);
      timer_trig <= 3'h0;
      wait_done(2);
      check_order({3, 4});
      apb(0, 8'h8c, 0);
      check(rd, {16'h0, 3'b101, ch[3], 8'h5c});
      apb(1, CTRL_OFS, 32'h1301);
      order.delete();
      timer_trig <= 3'h1;
      @(posedge pclk);
      timer_trig <= 3'h0;
      wait_done(2);
      check_order({5, 6});
      $display("sequence and burst test done");
      tally_and_finish();
   end
endmodule : adc_conversion_sequencer_test
